// ===== hdl/cbr_bridge.sv
// Purpose: CAN intensity message to LIN light command bridge, APB slave
// Assumes: received CAN frames arrive as a one-cycle strobe on pclk
// Notes:   LIN pin is open drain, oe high pulls the line dominant
`timescale 1ns/100ps
`default_nettype none
`include "cbr_params.svh"

module cbr_bridge
  import cbr_pkg::*;
#(
  parameter int BIT_CYCLES     = `CBR_BIT_CYC,
  parameter int TIMEOUT_CYCLES = `CBR_TIMEOUT_CYC,
  parameter int PERIOD_CYCLES  = `CBR_PERIOD_CYC
) (
  // clock, reset, enable
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`CBR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // received CAN frame
  input  wire logic                   can_rx_valid,
  input  wire logic [28:0]            can_rx_id,
  input  wire logic [3:0]             can_rx_dlc,
  input  wire logic [63:0]            can_rx_data,
  // LIN pin
  input  wire logic                   lin_rx_in,
  output logic                        lin_tx_out,
  output logic                        lin_tx_oe
);

  cbr_top_st_t s;
  cbr_top_st_t nx;
  cbr_frame_if fr ();

  logic                    acc;
  logic                    setup;
  logic                    wr;
  logic [7:0]              scaled [3];
  logic [`CBR_FRAME_W-1:0] frame;

  // one scaler per colour channel, CAN byte 1 is red
  for (genvar c = 0; c < 3; c++) begin : g_ch
    cbr_scale u_scale (
      .percent_raw (can_rx_data[c*`CBR_BYTE_W +: `CBR_BYTE_W]),
      .level       (scaled[c])
    );
  end

  // priority is not checked, any sender of the right group is taken
  assign acc = can_rx_valid
            && can_rx_id[`CBR_PGN_LSB +: 18] == `CBR_PGN
            && can_rx_dlc == `CBR_CAN_DLC;

  // command frame packing, fixed fields are constants
  always_comb begin
    frame                                = '0;
    frame[`CBR_F_BRIGHT +: 5]            = `CBR_BRIGHT_INIT;
    frame[`CBR_F_RSV0]                   = 1'b0;
    frame[`CBR_F_RAMP]                   = 1'b0;
    frame[`CBR_F_FADE]                   = 1'b0;
    frame[`CBR_F_RED +: `CBR_BYTE_W]     = s.red;
    frame[`CBR_F_GREEN +: `CBR_BYTE_W]   = s.green;
    frame[`CBR_F_BLUE +: `CBR_BYTE_W]    = s.blue;
    frame[`CBR_F_ZONE +: 4]              = `CBR_ZONE_ALL;
    frame[`CBR_F_RSV1 +: 4]              = 4'h0;
  end

  // APB phases
  assign setup = psel && !penable;
  assign wr    = psel && penable && s.pready && pwrite;

  // next state of the whole bridge
  always_comb begin
    nx         = s;
    nx.start   = 1'b0;
    nx.pready  = 1'b0;
    nx.pslverr = 1'b0;

    // pin input: three stages, change taken once stages two and three agree
    nx.sync = {s.sync[1:0], lin_rx_in};
    if (s.sync[1] == s.sync[2]) begin
      nx.rx = s.sync[2];
    end

    // message watchdog, reload on every accepted message
    if (acc) begin
      nx.alive = 1'b1;
      nx.tmo   = 32'(TIMEOUT_CYCLES);
      nx.red   = scaled[0];
      nx.green = scaled[1];
      nx.blue  = scaled[2];
    end else if (s.alive) begin
      if (s.tmo == 32'h0000_0001) begin
        nx.alive = 1'b0;
        nx.tmo   = 32'h0000_0000;
        nx.red   = `CBR_LEVEL_INIT;
        nx.green = `CBR_LEVEL_INIT;
        nx.blue  = `CBR_LEVEL_INIT;
      end else begin
        nx.tmo = 32'(s.tmo - 32'h0000_0001);
      end
    end

    // frame schedule: wait out a busy transmitter rather than skip
    if (s.per != 32'h0000_0000) begin
      nx.per = 32'(s.per - 32'h0000_0001);
    end else if (s.en && !fr.busy) begin
      nx.start = 1'b1;
      nx.per   = 32'(PERIOD_CYCLES - 1);
    end

    if (fr.done) begin
      nx.frames = 16'(s.frames + 16'h0001);
    end

    // read data is captured in the setup cycle, answer in the access cycle
    if (setup) begin
      nx.pready = 1'b1;
      nx.prdata = 32'h0000_0000;
      unique case (paddr)
        `CBR_A_CTRL: begin
          nx.prdata[0] = s.en;
        end
        `CBR_A_STATUS: begin
          nx.prdata[0]           = s.alive;
          nx.prdata[`CBR_S_BUSY] = fr.busy;
          nx.prdata[`CBR_S_ERR]  = s.err_st;
          nx.prdata[`CBR_S_TMO]  = s.tmo_st;
        end
        `CBR_A_LEVELS: begin
          nx.prdata[23:0] = {s.blue, s.green, s.red};
        end
        `CBR_A_FRAMES: begin
          nx.prdata[15:0] = s.frames;
        end
        default: begin
          nx.pslverr = 1'b1;
        end
      endcase
    end

    // writes land at the access edge only
    if (wr && paddr == `CBR_A_CTRL) begin
      nx.en = pwdata[0];
    end
    if (wr && paddr == `CBR_A_STATUS) begin
      if (pwdata[`CBR_S_ERR]) begin
        nx.err_st = 1'b0;
      end
      if (pwdata[`CBR_S_TMO]) begin
        nx.tmo_st = 1'b0;
      end
    end

    // sticky flags set after the clear, so a same-cycle event survives
    if (fr.err) begin
      nx.err_st = 1'b1;
    end
    if (s.alive && !acc && s.tmo == 32'h0000_0001) begin
      nx.tmo_st = 1'b1;
    end
  end

  // all state in one register, frozen while clk_en is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.en   <= `CBR_EN_RST;
      s.sync <= {3{`CBR_RX_IDLE}};
      s.rx   <= `CBR_RX_IDLE;
    end else if (clk_en) begin
      s <= nx;
    end
  end

  // hand-off to the transmitter
  assign fr.start = s.start;
  assign fr.data  = frame;
  assign fr.rx    = s.rx;

  cbr_lin_tx #(
    .BIT_CYC (16'(BIT_CYCLES))
  ) u_tx (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .fr      (fr.tx),
    .lin_out (lin_tx_out),
    .lin_oe  (lin_tx_oe)
  );

  // outputs straight from the state register
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // fixed fields on every started frame
  chk_const_byte: assert property (
    s.start |-> frame[7:0] == 8'h1F)
    else $error("byte 0 is not 0x1F");
  chk_zone_rsv: assert property (
    s.start |-> frame[39:32] == 8'h0F)
    else $error("zone byte is not 0x0F");
  chk_ramp_fade: assert property (
    s.start |-> (frame[6] == 1'b0 && frame[7] == 1'b0 && frame[5] == 1'b0))
    else $error("ramp, fade or reserved bit set");

  // full scale in gives full scale out, zero stays zero
  chk_full_scale: assert property (
    (clk_en && acc && can_rx_data[7:0] == 8'hFA) |=> s.red == 8'hFF)
    else $error("100 percent red not 0xFF");
  chk_zero_scale: assert property (
    (clk_en && acc && can_rx_data[23:16] == 8'h00) |=> s.blue == 8'h00)
    else $error("zero blue not 0x00");

  // silence ends in off
  chk_timeout_off: assert property (
    (clk_en && s.alive && !acc && s.tmo == 32'h0000_0001)
      |=> (!s.alive && s.red == 8'h00 && s.green == 8'h00 && s.tmo_st))
    else $error("watchdog did not turn levels off");
  chk_led_off: assert property (
    !s.alive |-> (s.red == 8'h00 && s.green == 8'h00 && s.blue == 8'h00))
    else $error("levels nonzero without message");
  chk_frame_start: assert property (
    (clk_en && s.start) |=> fr.busy)
    else $error("transmitter did not take the frame");

  // bus answers one cycle after setup
  chk_apb_answer: assert property (
    (clk_en && setup) |=> (s.pready && penable))
    else $error("no answer in access cycle");

  cov_msg_taken: cover property (acc && clk_en);
  cov_timeout: cover property (s.alive ##1 !s.alive);
  cov_frame_done: cover property (fr.done);
  cov_ctrl_write: cover property (wr && paddr == `CBR_A_CTRL);
endmodule

`default_nettype wire

// ===== hdl/cbr_params.svh
// Purpose: named constants of the CAN to LIN light command bridge
// Assumes: pclk at 125 MHz, APB register access, one LIN command frame
// Notes:   frame bit n is bit n of the 40-bit data vector, byte 0 first on the wire
// How it works
// - LIN link runs at 10417 bit/s.
// - frame id 0x23, five bytes, classic checksum.
// - bits 0-4 brightness, initial value 0x1F.
// - bit 5 and bits 36-39 sent as zero.
// - bit 6 ramp request, held zero.
// - bit 7 fade-out request, held zero.
// - red, green, blue bytes at bits 8/16/24.
// - zone mask at bit 32 is 0x0F.
// - CAN bytes 1..3 carry red, green, blue.
// - percent becomes 0x00-0xFF at 0.3922 %/bit.
// - byte 0 is constant 0x1F scalar.
// - 1000 ms silence returns levels to initial.
// - LED off while intensity message missing.
`ifndef CBR_PARAMS_SVH
`define CBR_PARAMS_SVH

// timing
`define CBR_CLK_HZ      125000000
`define CBR_LIN_BPS     10417
`define CBR_BIT_CYC     (`CBR_CLK_HZ / `CBR_LIN_BPS)
`define CBR_TIMEOUT_MS  1000
`define CBR_TIMEOUT_CYC (`CBR_TIMEOUT_MS * (`CBR_CLK_HZ / 1000))
`define CBR_PERIOD_MS   50
`define CBR_PERIOD_CYC  (`CBR_PERIOD_MS * (`CBR_CLK_HZ / 1000))

// LIN framing
`define CBR_BREAK_BITS  4'hD
`define CBR_STOP_BIT    4'h9
`define CBR_LAST_BYTE   3'h7
`define CBR_SYNC_BYTE   8'h55
`define CBR_FRAME_ID    6'h23
`define CBR_NBYTES      5
`define CBR_BYTE_W      8
`define CBR_FRAME_W     40

// frame fields
`define CBR_F_BRIGHT    0
`define CBR_F_RSV0      5
`define CBR_F_RAMP      6
`define CBR_F_FADE      7
`define CBR_F_RED       8
`define CBR_F_GREEN     16
`define CBR_F_BLUE      24
`define CBR_F_ZONE      32
`define CBR_F_RSV1      36
`define CBR_BRIGHT_INIT 5'h1F
`define CBR_ZONE_ALL    4'hF
`define CBR_LEVEL_INIT  8'h00

// CAN message
`define CBR_PGN         18'h0FF00
`define CBR_PGN_LSB     8
`define CBR_CAN_DLC     4'h8

// scaling: 0.4 %/bit in, 0.3922 %/bit out, 16-bit fraction
`define CBR_SCALE_MUL   17'h10517
`define CBR_SCALE_HALF  25'h0008000
`define CBR_LEVEL_MAX   8'hFF

// APB map and reset values
`define CBR_ADDR_W      12
`define CBR_A_CTRL      12'h000
`define CBR_A_STATUS    12'h004
`define CBR_A_LEVELS    12'h008
`define CBR_A_FRAMES    12'h00C
`define CBR_S_BUSY      1
`define CBR_S_ERR       2
`define CBR_S_TMO       3
`define CBR_EN_RST      1'b1
`define CBR_RX_IDLE     1'b1

`endif

// ===== hdl/cbr_pkg.sv
// Purpose: types shared by the bridge modules
// Assumes: cbr_params.svh defines the widths
// Notes:   each module keeps all its state in one of these structs
`include "cbr_params.svh"

package cbr_pkg;

  // transmitter states, gray along the frame path
  typedef enum logic [1:0] {
    CBR_IDLE  = 2'h0,
    CBR_BREAK = 2'h1,
    CBR_DELIM = 2'h3,
    CBR_BYTES = 2'h2
  } cbr_tx_state_t;

  typedef struct packed {
    cbr_tx_state_t          state;
    logic [15:0]            cyc;
    logic [3:0]             bitn;
    logic [2:0]             byten;
    logic [`CBR_FRAME_W-1:0] data;
    logic                   oe;
    logic                   pin;
    logic                   busy;
    logic                   done;
    logic                   err;
  } cbr_tx_st_t;

  typedef struct packed {
    logic        en;
    logic        alive;
    logic [7:0]  red;
    logic [7:0]  green;
    logic [7:0]  blue;
    logic [31:0] tmo;
    logic [31:0] per;
    logic [15:0] frames;
    logic        err_st;
    logic        tmo_st;
    logic        start;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [2:0]  sync;
    logic        rx;
  } cbr_top_st_t;

endpackage

// ===== hdl/cbr_frame_if.sv
// Purpose: frame hand-off between bridge control and LIN transmitter
// Assumes: both ends on pclk
// Notes:   start is a one-cycle pulse, data is sampled with it
`timescale 1ns/100ps
`default_nettype none
`include "cbr_params.svh"

interface cbr_frame_if;
  logic                    start;
  logic [`CBR_FRAME_W-1:0] data;
  logic                    rx;
  logic                    busy;
  logic                    done;
  logic                    err;
  modport ctl (output start, data, rx, input busy, done, err);
  modport tx  (input start, data, rx, output busy, done, err);
endinterface

`default_nettype wire

// ===== hdl/cbr_scale.sv
// Purpose: percent intensity byte to LIN channel level
// Assumes: input at 0.4 %/bit, output at 0.3922 %/bit
// Notes:   rounds to nearest, clamps above full scale
`timescale 1ns/100ps
`default_nettype none
`include "cbr_params.svh"

module cbr_scale
  import cbr_pkg::*;
(
  // percent in
  input  wire logic [7:0] percent_raw,
  // level out
  output logic      [7:0] level
);
  logic [24:0] prod;
  logic [8:0]  quot;

  // fixed-point multiply avoids a divider in the data path
  always_comb begin
    // widen both operands first, a 17-bit product would lose the top bits
    prod  = 25'(percent_raw) * 25'(`CBR_SCALE_MUL) + `CBR_SCALE_HALF;
    quot  = prod[24:16];
    level = quot[8] ? `CBR_LEVEL_MAX : quot[7:0];
  end
endmodule

`default_nettype wire

// ===== hdl/cbr_lin_tx.sv
// Purpose: LIN master frame transmitter, break to checksum
// Assumes: open-drain pin, rx already synchronised
// Notes:   readback compared at mid bit, error is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
`include "cbr_params.svh"

module cbr_lin_tx
  import cbr_pkg::*;
#(
  parameter logic [15:0] BIT_CYC = 16'(`CBR_BIT_CYC)
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // frame hand-off
  cbr_frame_if.tx   fr,
  // LIN pin
  output logic      lin_out,
  output logic      lin_oe
);
  cbr_tx_st_t s;
  cbr_tx_st_t nx;
  logic [7:0] cur;
  logic [3:0] nb;

  function automatic logic [7:0] pid_of(input logic [5:0] id);
    pid_of = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction

  // classic checksum: data only, carry wrapped back in
  function automatic logic [7:0] cks_of(input logic [`CBR_FRAME_W-1:0] d);
    logic [8:0] acc;
    acc = 9'h000;
    for (int i = 0; i < `CBR_NBYTES; i++) begin
      acc = {1'b0, acc[7:0]} + {1'b0, d[i*`CBR_BYTE_W +: `CBR_BYTE_W]};
      acc = {1'b0, acc[7:0]} + {8'h00, acc[8]};
    end
    cks_of = ~acc[7:0];
  endfunction

  // byte on the wire: sync, protected id, five data bytes, checksum
  always_comb begin
    unique case (s.byten)
      3'h0:           cur = `CBR_SYNC_BYTE;
      3'h1:           cur = pid_of(`CBR_FRAME_ID);
      `CBR_LAST_BYTE: cur = cks_of(s.data);
      default:        cur = 8'(s.data >> {3'(s.byten - 3'h2), 3'h0});
    endcase
  end

  // one bit timer drives every state but idle, so all bit edges share one rate
  always_comb begin
    nx      = s;
    nx.done = 1'b0;
    nx.err  = 1'b0;
    nx.pin  = 1'b0;
    nb      = 4'(s.bitn + 4'h1);
    unique case (s.state)
      CBR_IDLE: begin
        if (fr.start) begin
          nx.state = CBR_BREAK;
          nx.data  = fr.data;
          nx.cyc   = 16'h0000;
          nx.bitn  = 4'h0;
          nx.busy  = 1'b1;
          nx.oe    = 1'b1;
        end
      end
      default: begin
        if (s.cyc == (BIT_CYC >> 1) && fr.rx == s.oe) begin
          nx.err = 1'b1;
        end
        if (s.cyc == BIT_CYC - 16'h0001) begin
          nx.cyc  = 16'h0000;
          nx.bitn = nb;
          if (s.state == CBR_BREAK && nb == `CBR_BREAK_BITS) begin
            nx.state = CBR_DELIM;
            nx.oe    = 1'b0;
          end else if (s.state == CBR_DELIM) begin
            nx.state = CBR_BYTES;
            nx.byten = 3'h0;
            nx.bitn  = 4'h0;
            nx.oe    = 1'b1;
          end else if (s.state == CBR_BYTES && s.bitn == `CBR_STOP_BIT) begin
            nx.bitn  = 4'h0;
            nx.byten = 3'(s.byten + 3'h1);
            nx.oe    = 1'b1;
            if (s.byten == `CBR_LAST_BYTE) begin
              nx.state = CBR_IDLE;
              nx.busy  = 1'b0;
              nx.done  = 1'b1;
              nx.oe    = 1'b0;
            end
          end else if (s.state == CBR_BYTES) begin
            nx.oe = (nb == `CBR_STOP_BIT) ? 1'b0 : ~cur[3'(nb - 4'h1)];
          end
        end else begin
          nx.cyc = 16'(s.cyc + 16'h0001);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= nx;
    end
  end

  assign lin_out = s.pin;
  assign lin_oe  = s.oe;
  assign fr.busy = s.busy;
  assign fr.done = s.done;
  assign fr.err  = s.err;

  // pin edges only at bit boundaries or frame start
  chk_bit_edges: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s.oe) |-> ($past(s.cyc) == BIT_CYC - 16'h0001 || $past(s.state) == CBR_IDLE))
    else $error("pin changed inside a bit");
  chk_pid_value: assert property (@(posedge pclk) disable iff (!presetn)
    (s.state == CBR_BYTES && s.byten == 3'h1) |-> cur == 8'hA3)
    else $error("protected id is not 0xA3");
  chk_stop_recessive: assert property (@(posedge pclk) disable iff (!presetn)
    (s.state == CBR_BYTES && s.bitn == `CBR_STOP_BIT) |-> !s.oe)
    else $error("stop bit driven dominant");
  chk_done_ends: assert property (@(posedge pclk) disable iff (!presetn)
    (s.done && ce) |=> (!s.done && !s.busy && s.state == CBR_IDLE))
    else $error("done not a single pulse");
endmodule

`default_nettype wire

// ===== bench/cbr_lin_slave.sv
// Purpose: behavioural lighting slave listening on the LIN wire
// Assumes: wire resolved with its pull-up by the bench
// Notes:   listens only, so the master's readback stays clean
`timescale 1ns/100ps
`default_nettype none

module cbr_lin_slave #(
  parameter int BIT = 16
) (
  // bus
  input  wire logic        pclk,
  input  wire logic        lin_bus,
  // decoded frame
  output logic      [63:0] rx_bytes,
  output logic             stop_ok,
  output var int           brk_len,
  output var int           n_frames
);
  int n;

  // break length in clocks, then eight bytes sampled at mid bit
  always begin
    @(negedge lin_bus);
    n = 0;
    while (lin_bus === 1'b0) begin
      @(posedge pclk);
      n++;
    end
    brk_len = n;
    stop_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge lin_bus);
      repeat (BIT / 2) @(posedge pclk);
      for (int k = 0; k < 8; k++) begin
        repeat (BIT) @(posedge pclk); // one bit time apart
        rx_bytes[8*i+k] = lin_bus;   // lsb first
      end
      repeat (BIT) @(posedge pclk);
      if (lin_bus !== 1'b1) stop_ok = 1'b0;
    end
    n_frames++;
  end
endmodule

`default_nettype wire

// ===== bench/can_to_lin_light_command_bridge_test.sv
// Purpose: self-checking bench of the CAN to LIN light bridge
// Assumes: short bit, period and timeout counts
// Notes:   levels waited for over two frames so no frame is partial
`timescale 1ns/100ps
`default_nettype none

module can_to_lin_light_command_bridge_test;
  localparam int B   = 16;
  localparam int TMO = 20000;
  localparam int PER = 3000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        can_valid = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [28:0] can_id = '0;
  logic [3:0]  can_dlc = '0;
  logic [63:0] can_data = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, tx_oe, tx_out, stop_ok;
  logic [63:0] rx_bytes;
  logic [7:0]  r, g, b;
  logic [7:0]  cor [4] = '{8'h00, 8'h19, 8'hFA, 8'hFF};
  int          n_fail = 0;
  int          n_checks = 0;
  int          brk_len, n_frames;
  wire         lin_bus;

  // open drain line with pull-up
  assign lin_bus = tx_oe ? 1'b0 : 1'b1;
  always #4 pclk = ~pclk;

  cbr_bridge #(.BIT_CYCLES(B), .TIMEOUT_CYCLES(TMO), .PERIOD_CYCLES(PER)) u_cbr_bridge (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .can_rx_valid(can_valid), .can_rx_id(can_id), .can_rx_dlc(can_dlc),
    .can_rx_data(can_data), .lin_rx_in(lin_bus), .lin_tx_out(tx_out), .lin_tx_oe(tx_oe));

  cbr_lin_slave #(.BIT(B)) u_cbr_lin_slave (
    .pclk(pclk), .lin_bus(lin_bus), .rx_bytes(rx_bytes), .stop_ok(stop_ok),
    .brk_len(brk_len), .n_frames(n_frames));

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // look at the answer mid cycle, where it has settled, then let its edge pass
    do begin
      @(negedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) n_fail++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // sender side: priority 6, eight bytes, one-cycle strobe
  task automatic can(input logic [17:0] pgn, input logic [3:0] dlc,
                     input logic [7:0] cr, input logic [7:0] cg, input logic [7:0] cb);
    @(posedge pclk);
    can_valid <= 1'b1;
    can_id <= {3'h6, pgn, 8'($urandom)};
    can_dlc <= dlc;
    can_data <= {32'($urandom), 8'($urandom), cb, cg, cr};
    @(posedge pclk);
    can_valid <= 1'b0;
  endtask

  // percent at 0.4 per bit to level at 0.3922 per bit, rounded
  function automatic logic [7:0] lvl(input logic [7:0] p);
    int q;
    q = (p * 8000 + 3922) / 7844;
    return (q > 255) ? 8'hFF : 8'(q);
  endfunction

  function automatic logic [7:0] csum(input logic [39:0] d);
    int s;
    s = 0;
    for (int i = 0; i < 5; i++) begin
      s = s + d[8*i+:8];
      if (s > 255) s = s - 255;
    end
    return ~8'(s);
  endfunction

  // skip the frame in flight, then check the next whole one
  task automatic frame(input logic [7:0] cr, input logic [7:0] cg, input logic [7:0] cb);
    int f;
    f = n_frames + 2;
    for (int t = 0; t < 3 * PER && n_frames < f; t++) @(posedge pclk);
    chk("count", 64'(n_frames >= f), 64'h1);
    chk("break", 64'(brk_len >= 13 * B && brk_len <= 13 * B + 1), 64'h1);
    chk("sync", rx_bytes[7:0], 8'h55);
    chk("pid", rx_bytes[15:8], 8'hA3);
    chk("bright", rx_bytes[20:16], 5'h1F);
    chk("rsv0", rx_bytes[21], 1'b0);
    chk("ramp", rx_bytes[22], 1'b0);
    chk("fade", rx_bytes[23], 1'b0);
    chk("rgb", rx_bytes[47:24], {cb, cg, cr});
    chk("zone", rx_bytes[51:48], 4'hF);
    chk("rsv1", rx_bytes[55:52], 4'h0);
    chk("csum", rx_bytes[63:56], csum({8'h0F, cb, cg, cr, 8'h1F}));
    chk("stop", stop_ok, 1'b1);
    chk("txout", tx_out, 1'b0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog sized well past the roughly 65k cycles the tests need
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    summarize();
  end

  initial begin
    void'($urandom(25));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // reset state, register access, unmapped place
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("levels", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", err, 1'b1);
    frame(8'h00, 8'h00, 8'h00);
    $display("test reset done");
    // corners then random, each chased by refused messages
    for (int i = 0; i < 6; i++) begin
      r = (i < 4) ? cor[i] : 8'($urandom);
      g = (i < 4) ? cor[3-i] : 8'($urandom);
      b = 8'($urandom);
      can(18'h0FF00, 4'h8, r, g, b);
      can(18'h0FF01, 4'h8, ~r, ~g, ~b);
      can(18'h0FF00, 4'h7, ~r, ~g, ~b);
      apb(1'b0, 12'h008, 32'h0);
      chk("levels", rd, {8'h00, lvl(b), lvl(g), lvl(r)});
      frame(lvl(r), lvl(g), lvl(b));
    end
    $display("test levels done");
    // silence just short of and just past the limit
    can(18'h0FF00, 4'h8, 8'hFA, 8'hFA, 8'hFA);
    repeat (TMO - 60) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("held", rd, 32'h00FFFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk("alive", rd[0], 1'b1);
    repeat (100) @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    chk("expired", rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("lost", {rd[3], rd[0]}, 2'b10);
    frame(8'h00, 8'h00, 8'h00);
    $display("test timeout done");
    summarize();
  end
endmodule

`default_nettype wire
